// ==== shared/eiw_map.svh ====
// eiw_map.svh: source indices, timing counts and parameter defaults for the external interrupt wake block
// assumes a 50 MHz system clock; included by bare name
`ifndef EIW_MAP_SVH
`define EIW_MAP_SVH
`define EIW_CLK_PERIOD_NS     20
`define EIW_PD_WAKE_MIN_NS    50
// least time rounds up to whole cycles
`define EIW_PD_WAKE_CYCLES    ((`EIW_PD_WAKE_MIN_NS + `EIW_CLK_PERIOD_NS - 1) / `EIW_CLK_PERIOD_NS)
`define EIW_STATE_DIV_DEFAULT 2
`define EIW_NUM_IRQ_DEFAULT   8
`define EIW_NMI_INDEX         0
`define EIW_EXT_INDEX         1
`endif

// ==== shared/eiw_pkg.sv ====
// eiw_pkg.sv: types shared by the external interrupt wake block
// assumes eiw_map.svh for numeric constants
package eiw_pkg;
  typedef enum logic [1:0] {
    EIW_MODE_NORMAL,
    EIW_MODE_IDLE,
    EIW_MODE_PWRDN
  } eiw_mode_t;

  typedef enum logic [1:0] {
    EIW_RES_NONE,
    EIW_RES_ISR,
    EIW_RES_NEXT
  } eiw_resume_t;

  typedef struct packed {
    logic        wake;
    eiw_resume_t resume;
  } eiw_wake_t;
endpackage : eiw_pkg

// ==== verilog/eiw_edge_sync.sv ====
// eiw_edge_sync.sv: two-flop synchroniser with sampled rising-edge detect
// assumes pin_i is asynchronous to sys_clk_i; sample_en_i is a one-cycle enable
`timescale 1ns/1ns
`default_nettype none
module eiw_edge_sync (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic pin_i,
  input  wire logic sample_en_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta_q;
  logic sync_q;
  logic samp_q;
  logic prev_q;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // the edge is judged only on phase-2 samples, so a glitch between samples is not seen
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      samp_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (sample_en_i) begin
      samp_q <= sync_q;
      prev_q <= samp_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = samp_q & ~prev_q; // [R11]
endmodule : eiw_edge_sync
`default_nettype wire

// ==== verilog/eiw_core.sv ====
// eiw_core.sv: external/nonmaskable interrupt pending logic and idle/powerdown wake
// assumes mode and enables come from the core on sys_clk_i; pins are asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "eiw_map.svh"
// Contract
// R1: in normal mode a rising edge on the external pin sets its pending bit.
// R2: the external pin is sampled only while the clock output is high.
// R3: the source holds the external pin high at least one state time.
// R4: in powerdown, the external pin held at least 50 ns wakes the device.
// R5: powerdown wake ignores the enable but needs special-function pin configuration.
// R6: after powerdown wake, run the service routine if enabled, else next instruction.
// R7: in idle, any enabled asserted interrupt wakes the device.
// R8: in normal mode a nonmaskable rising edge raises a request regardless of enables.
// R9: the nonmaskable request wins priority over all other pending sources.
// R10: the source holds the nonmaskable pin longer than one state time.
// R11: edges come from consecutive samples; pending stays set until cleared.
module eiw_core #(
  parameter int NUM_IRQ   = `EIW_NUM_IRQ_DEFAULT,
  parameter int STATE_DIV = `EIW_STATE_DIV_DEFAULT
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 ext_irq_pin_i,
  input  wire logic                 nmi_pin_i,
  input  wire logic                 ext_irq_sf_sel_i,
  input  wire eiw_pkg::eiw_mode_t   mode_i,
  input  wire logic [NUM_IRQ-1:0]   irq_enable_i,
  input  wire logic [NUM_IRQ-1:0]   periph_pend_i,
  input  wire logic [NUM_IRQ-1:0]   pend_clear_i,
  output logic                      clock_output_pin_o,
  output logic [NUM_IRQ-1:0]        pending_o,
  output logic                      irq_req_o,
  output logic [$clog2(NUM_IRQ)-1:0] irq_id_o,
  output eiw_pkg::eiw_wake_t        wake_o
);
  import eiw_pkg::*;

  localparam int IW = $clog2(NUM_IRQ);
  localparam int CW = (STATE_DIV > 1) ? $clog2(STATE_DIV) : 1;
  localparam logic [7:0] PD_CYC = 8'(`EIW_PD_WAKE_CYCLES);

  logic [CW-1:0]      div_q;
  logic               clock_output_pin_q;
  logic               phase2_en;
  logic               ext_level;
  logic               ext_rise;
  logic               nmi_level;
  logic               nmi_rise;
  logic [NUM_IRQ-1:0] pend_q;
  logic [NUM_IRQ-1:0] set_vec;
  logic [7:0]         pd_cnt_q;
  logic               pd_wake;
  logic               idle_wake;
  eiw_wake_t          wake_q;
  logic               req_q;
  logic [IW-1:0]      id_q;

  // lowest index wins; index 0 is the nonmaskable source
  function automatic logic [IW-1:0] eiw_first(input logic [NUM_IRQ-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction : eiw_first

  // state-time divider: clock output high for the second half of each state
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      div_q    <= '0;
      clock_output_pin_q <= 1'b0;
    end else begin
      if (div_q == CW'(STATE_DIV - 1)) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + CW'(1);
      end
      clock_output_pin_q <= (div_q >= CW'(STATE_DIV / 2 - 1)) && (div_q != CW'(STATE_DIV - 1));
    end
  end

  // sample strobe sits in the clock-output-high phase
  assign phase2_en = clock_output_pin_q; // [R2]

  eiw_edge_sync u_ext_sync (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .pin_i       (ext_irq_pin_i),
    .sample_en_i (phase2_en),
    .level_o     (ext_level),
    .rise_o      (ext_rise)
  );

  eiw_edge_sync u_nmi_sync (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .pin_i       (nmi_pin_i),
    .sample_en_i (phase2_en),
    .level_o     (nmi_level),
    .rise_o      (nmi_rise)
  );

  always_comb begin
    set_vec = periph_pend_i;
    set_vec[`EIW_NMI_INDEX] = 1'b0;
    set_vec[`EIW_EXT_INDEX] = periph_pend_i[`EIW_EXT_INDEX];
    // idle keeps latching pin edges, otherwise an enabled pin could never end idle [R7]
    if (mode_i != EIW_MODE_PWRDN) begin
      // a single-cycle strobe per sample means one set per edge
      set_vec[`EIW_NMI_INDEX] = nmi_rise & phase2_en; // [R8]
      set_vec[`EIW_EXT_INDEX] = periph_pend_i[`EIW_EXT_INDEX] | (ext_rise & phase2_en & ext_irq_sf_sel_i); // [R1]
    end else begin
      // the routine must find its request pending after a powerdown wake
      set_vec[`EIW_EXT_INDEX] = periph_pend_i[`EIW_EXT_INDEX] | (pd_wake & irq_enable_i[`EIW_EXT_INDEX]); // [R6]
    end
  end

  // set wins over a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_pend
      always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
          pend_q[g] <= 1'b0;
        end else if (set_vec[g]) begin
          pend_q[g] <= 1'b1; // [R11]
        end else if (pend_clear_i[g]) begin
          pend_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // powerdown: raw synchronised level, no phase-2 gating, as the state clock may be stopped
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pd_cnt_q <= '0;
    end else if (mode_i == EIW_MODE_PWRDN && ext_level && ext_irq_sf_sel_i) begin // [R5]
      if (pd_cnt_q != 8'hff) begin
        pd_cnt_q <= pd_cnt_q + 8'h01;
      end
    end else begin
      pd_cnt_q <= '0;
    end
  end

  assign pd_wake   = (mode_i == EIW_MODE_PWRDN) && (pd_cnt_q == PD_CYC); // [R4]
  // nmi counts as always enabled
  assign idle_wake = (mode_i == EIW_MODE_IDLE) &&
                     (|((pend_q | set_vec) & (irq_enable_i | NUM_IRQ'(1)))); // [R7]

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wake_q <= '{wake: 1'b0, resume: EIW_RES_NONE};
    end else if (pd_wake) begin
      wake_q.wake   <= 1'b1;
      wake_q.resume <= irq_enable_i[`EIW_EXT_INDEX] ? EIW_RES_ISR : EIW_RES_NEXT; // [R6]
    end else if (idle_wake) begin
      wake_q.wake   <= 1'b1;
      wake_q.resume <= EIW_RES_ISR;
    end else begin
      wake_q <= '{wake: 1'b0, resume: EIW_RES_NONE};
    end
  end

  // powerdown wake with the interrupt enabled also leaves the ext bit pending for the ISR
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      req_q <= 1'b0;
      id_q  <= '0;
    end else begin
      req_q <= |(pend_q & (irq_enable_i | NUM_IRQ'(1)));
      id_q  <= eiw_first(pend_q & (irq_enable_i | NUM_IRQ'(1))); // [R9]
    end
  end

  // registered copy keeps the output straight off a flop; it trails the internal bits by one cycle
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pending_o <= '0;
    end else begin
      pending_o <= pend_q;
    end
  end

  assign clock_output_pin_o = clock_output_pin_q;
  assign irq_req_o          = req_q;
  assign irq_id_o           = id_q;
  assign wake_o             = wake_q;
endmodule : eiw_core
`default_nettype wire

// ==== testbench/eiw_src.sv ====
// eiw_src.sv: model of the outside circuitry driving the interrupt pins
// assumes the bench calls pulse() with cyc of three or more
`timescale 1ns/1ns
`default_nettype none
module eiw_src (
  input  wire logic sys_clk_i,
  output logic      ext_o,
  output logic      nmi_o
);
  initial begin
    ext_o = 1'b0;
    nmi_o = 1'b0;
  end
  // pins are pulled low, so a released pin reads low
  task pulse(input logic e, input logic n, input int cyc);
    @(posedge sys_clk_i);
    #2;
    ext_o = e;
    nmi_o = n;
    repeat (cyc) @(posedge sys_clk_i);
    #2;
    ext_o = 1'b0;
    nmi_o = 1'b0;
  endtask : pulse
endmodule : eiw_src
`default_nettype wire

// ==== testbench/eiw_core_chk.sv ====
// eiw_core_chk.sv: assertions on the eiw_core ports
// assumes a two-cycle state time; bound to every eiw_core
`timescale 1ns/1ns
`default_nettype none
module eiw_core_chk #(
  parameter int NUM_IRQ   = 8,
  parameter int STATE_DIV = 2
) (
  input wire logic                       sys_clk_i,
  input wire logic                       resetn_i,
  input wire logic                       ext_irq_pin_i,
  input wire logic                       nmi_pin_i,
  input wire logic                       ext_irq_sf_sel_i,
  input wire eiw_pkg::eiw_mode_t         mode_i,
  input wire logic [NUM_IRQ-1:0]         irq_enable_i,
  input wire logic [NUM_IRQ-1:0]         periph_pend_i,
  input wire logic [NUM_IRQ-1:0]         pend_clear_i,
  input wire logic                       clock_output_pin_o,
  input wire logic [NUM_IRQ-1:0]         pending_o,
  input wire logic                       irq_req_o,
  input wire logic [$clog2(NUM_IRQ)-1:0] irq_id_o,
  input wire eiw_pkg::eiw_wake_t         wake_o
);
  import eiw_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic nrm = (mode_i == EIW_MODE_NORMAL);
  wire logic pd  = (mode_i == EIW_MODE_PWRDN);
  a_state_clk: assert property (clock_output_pin_o |=> !clock_output_pin_o ##1 clock_output_pin_o)
    else $error("state clock off");
  a_ext_set: assert property ($rose(ext_irq_pin_i) && nrm && ext_irq_sf_sel_i ##1 (ext_irq_pin_i && nrm)[*3]
    |-> ##[0:6] pending_o[1]) else $error("ext not pending");
  a_nmi_set: assert property ($rose(nmi_pin_i) && nrm ##1 (nmi_pin_i && nrm)[*3] |-> ##[0:6] pending_o[0])
    else $error("nmi not pending");
  a_nmi_wins: assert property (pending_o[0] && $past(pending_o[0]) |-> irq_req_o && irq_id_o == '0)
    else $error("nmi lost");
  a_pend_hold: assert property ($fell(pending_o[1]) |-> $past(pend_clear_i[1]) || $past(pend_clear_i[1], 2))
    else $error("pending dropped");
  a_pd_wake: assert property ($rose(ext_irq_pin_i) && pd && ext_irq_sf_sel_i ##1 (ext_irq_pin_i && pd)[*3]
    |-> ##[1:6] wake_o.wake && wake_o.resume == (irq_enable_i[1] ? EIW_RES_ISR : EIW_RES_NEXT))
    else $error("bad powerdown wake");
  a_pd_nosel: assert property ((pd && !ext_irq_sf_sel_i && !nmi_pin_i)[*3] |-> !wake_o.wake)
    else $error("wake unselected");
  a_idle_wake: assert property (nrm ##1 mode_i == EIW_MODE_IDLE && (pending_o[0] || |(pending_o & irq_enable_i))
    |-> ##[0:3] wake_o.wake) else $error("idle not woken");
  c_wake_isr: cover property (wake_o.wake && wake_o.resume == EIW_RES_ISR);
  c_wake_next: cover property (wake_o.wake && wake_o.resume == EIW_RES_NEXT);
  c_nmi_req: cover property (irq_req_o && pending_o[0]);
endmodule : eiw_core_chk
bind eiw_core eiw_core_chk #(.NUM_IRQ(NUM_IRQ), .STATE_DIV(STATE_DIV)) eiw_core_chk_i (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ext_irq_pin_i(ext_irq_pin_i), .nmi_pin_i(nmi_pin_i),
  .ext_irq_sf_sel_i(ext_irq_sf_sel_i), .mode_i(mode_i), .irq_enable_i(irq_enable_i),
  .periph_pend_i(periph_pend_i), .pend_clear_i(pend_clear_i), .clock_output_pin_o(clock_output_pin_o),
  .pending_o(pending_o), .irq_req_o(irq_req_o), .irq_id_o(irq_id_o), .wake_o(wake_o));
`default_nettype wire

// ==== testbench/eiw_core_tb.sv ====
// eiw_core_tb.sv: directed bench for eiw_core
// assumes eiw_src on the pins and the bound checker
`timescale 1ns/1ns
`default_nettype none
module eiw_core_tb;
  import eiw_pkg::*;
  logic       sys_clk_i, resetn_i, sf, ext_pin, nmi_pin, clk_out, req, c0;
  eiw_mode_t  mode;
  logic [7:0] en, pp, clr, pend;
  logic [2:0] id;
  eiw_wake_t  wake, w;
  int         err_count, checks;
  eiw_core eiw_core_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ext_irq_pin_i(ext_pin), .nmi_pin_i(nmi_pin),
    .ext_irq_sf_sel_i(sf), .mode_i(mode), .irq_enable_i(en), .periph_pend_i(pp), .pend_clear_i(clr),
    .clock_output_pin_o(clk_out), .pending_o(pend), .irq_req_o(req), .irq_id_o(id), .wake_o(wake));
  eiw_src eiw_src_i (.sys_clk_i(sys_clk_i), .ext_o(ext_pin), .nmi_o(nmi_pin));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask : step
  // a powerdown wake lasts one cycle, so every cycle is looked at
  task watch(input int n);
    w = '0;
    repeat (n) begin
      step(1);
      if (wake.wake === 1'b1) w = wake;
    end
  endtask : watch
  task pd_wake(input logic [7:0] exp);
    fork
      eiw_src_i.pulse(1'b1, 1'b0, 6);
      watch(14);
    join
    chk({5'h0, w}, exp);
  endtask : pd_wake
  task t_ext;
    eiw_src_i.pulse(1'b1, 1'b0, 4);
    step(6);
    chk(pend, 8'h02);
    chk({req, 4'h0, id}, 8'h81);
    clr = 8'h02;
    step(1);
    clr = 8'h00;
    step(2);
    chk(pend, 8'h00);
  endtask : t_ext
  task t_sf_off;
    sf = 1'b0;
    eiw_src_i.pulse(1'b1, 1'b0, 4);
    step(6);
    chk(pend, 8'h00);
    sf = 1'b1;
  endtask : t_sf_off
  // nmi enable bit left low: the request must come anyway
  task t_nmi;
    eiw_src_i.pulse(1'b1, 1'b1, 4);
    step(6);
    chk(pend, 8'h03);
    chk({req, 4'h0, id}, 8'h80);
    clr = 8'h03;
    step(1);
    clr = 8'h00;
  endtask : t_nmi
  task t_pd;
    mode = EIW_MODE_PWRDN;
    en = 8'h00;
    pd_wake({5'h0, 1'b1, EIW_RES_NEXT});
    en = 8'h02;
    pd_wake({5'h0, 1'b1, EIW_RES_ISR});
    chk(pend, 8'h02);
    clr = 8'h02;
    step(1);
    clr = 8'h00;
    sf = 1'b0;
    pd_wake(8'h00);
    sf = 1'b1;
    chk(pend, 8'h00);
    mode = EIW_MODE_NORMAL;
  endtask : t_pd
  task t_idle;
    en = 8'h04;
    pp = 8'h04;
    step(1);
    pp = 8'h00;
    step(2);
    mode = EIW_MODE_IDLE;
    watch(4);
    chk({5'h0, w}, {5'h0, 1'b1, EIW_RES_ISR});
    mode = EIW_MODE_NORMAL;
    clr = 8'h04;
    step(1);
    clr = 8'h00;
    // an enabled pin edge while idle must end idle too
    en = 8'h02;
    mode = EIW_MODE_IDLE;
    fork
      eiw_src_i.pulse(1'b1, 1'b0, 4);
      watch(12);
    join
    chk({5'h0, w}, {5'h0, 1'b1, EIW_RES_ISR});
    mode = EIW_MODE_NORMAL;
    chk(pend, 8'h02);
    clr = 8'h02;
    step(1);
    clr = 8'h00;
  endtask : t_idle
  task final_report;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  initial begin
    #(20 * 2000);
    err_count++;
    final_report();
  end
  initial begin
    {resetn_i, pp, clr, err_count, checks} = '0;
    sf = 1'b1;
    mode = EIW_MODE_NORMAL;
    en = 8'h02;
    repeat (12) @(posedge sys_clk_i);
    #2;
    resetn_i = 1'b1;
    step(2);
    chk(pend, 8'h00);
    chk({req, 4'h0, id}, 8'h00);
    c0 = clk_out;
    step(1);
    chk({7'h0, clk_out ^ c0}, 8'h01);
    t_ext();
    t_sf_off();
    t_nmi();
    t_pd();
    t_idle();
    final_report();
  end
endmodule : eiw_core_tb
`default_nettype wire
